// ---- core/mfre_map.vh ----
// Opcodes, phase lengths, field positions and reset values of the fast read engine
`ifndef MFRE_MAP_VH
`define MFRE_MAP_VH

// Accepted opcodes
`define MFRE_OP_QUAD_OUT      8'h6B
`define MFRE_OP_DUAL_IO       8'hBB
`define MFRE_OP_QUAD_IO       8'hEB

// Transfer kinds
`define MFRE_KIND_QO          2'h0
`define MFRE_KIND_DIO         2'h1
`define MFRE_KIND_QIO         2'h2

// Clock counts of each phase
`define MFRE_CMD_CLKS_SPI     5'h08
`define MFRE_CMD_CLKS_QPI     5'h02
`define MFRE_ADDR_CLKS_X1     5'h18
`define MFRE_ADDR_CLKS_X2     5'h0C
`define MFRE_ADDR_CLKS_X4     5'h06
`define MFRE_MODE_CLKS_X2     5'h04
`define MFRE_MODE_CLKS_X4     5'h02
`define MFRE_DUMMY_CLKS_QO    5'h08
`define MFRE_DUMMY_CLKS_DIO   5'h00
`define MFRE_DUMMY_CLKS_QIO   5'h04

// Mode byte: opcode skip field and the value that keeps the skip
`define MFRE_SKIP_HI          5
`define MFRE_SKIP_LO          4
`define MFRE_SKIP_KEEP        2'h2

// Wrap setup field {length[1:0], disable}
`define MFRE_WRAP_DIS_BIT     0
`define MFRE_WRAP_LEN_HI      2
`define MFRE_WRAP_LEN_LO      1
`define MFRE_WRAP_DIS_RST     1'h1
`define MFRE_WRAP_LEN_RST     2'h0

// Read parameter dummy select, reset value selects zero clocks
`define MFRE_RDPAR_RST        2'h0

`endif

// ---- core/mfre_buf2.v ----
// Two-entry valid/ready buffer with flush
`timescale 1ns/1ps
module mfre_buf2 #(
   parameter DW = 8
) (
   input  wire          sys_clk_i,
   input  wire          rst_i,
   input  wire          flush_i,
   input  wire          in_valid_i,
   output wire          in_ready_o,
   input  wire [DW-1:0] in_data_i,
   output wire          out_valid_o,
   input  wire          out_ready_i,
   output wire [DW-1:0] out_data_o
);
   reg [DW-1:0] mem_ff [0:1];
   reg          wr_ptr_ff;
   reg          rd_ptr_ff;
   reg [1:0]    cnt_ff;
   wire         push;
   wire         pop;

   assign in_ready_o  = (cnt_ff != 2'h2);
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o  = mem_ff[rd_ptr_ff];
   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
         mem_ff[0] <= {DW{1'b0}};
         mem_ff[1] <= {DW{1'b0}};
      end else if (flush_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         cnt_ff    <= 2'h0;
      end else begin
         if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
            wr_ptr_ff         <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         if (push & ~pop) begin
            cnt_ff <= cnt_ff + 2'h1;
         end else if (pop & ~push) begin
            cnt_ff <= cnt_ff - 2'h1;
         end
      end
   end
endmodule

// ---- core/mfre_engine.v ----
// Device-side multi-line fast read engine of a serial flash
`timescale 1ns/1ps
`include "mfre_map.vh"

// Behaviour
// - Quad output read: 24 address bits on one line, eight dummies, data on four.
// - Quad output read is refused unless the quad enable bit is one.
// - Dual I/O read: address two bits per clock, data on lines 0 and 1.
// - Mode byte follows the address; bits 5:4 steer opcode skip, the other bits are ignored.
// - Skip bits equal 10 let the next dual read start with its address.
// - Any other skip value restores opcode decoding on the next select.
// - Quad I/O read in single-line mode: four-line address, four dummy clocks.
// - Quad I/O read runs only with the quad enable bit set, except one started by opcode skip.
// - Skip bits equal 10 make the next quad I/O read start with its address.
// - With wrap on, single-line quad I/O read loops inside its aligned section.
// - Wrap setup stores a disable bit and a two-bit length field.
// - Quad-instruction dummies are 0, 2, 4 or 6; reset selects 0.
// - Quad-instruction mode adds its dummy clocks after the mode byte clocks.
// - Opcode skip also works for quad I/O read in quad-instruction mode.
// - Quad I/O read never wraps in quad-instruction mode.
// - Wrap on when disable bit is zero; lengths 8, 16, 32, 64 bytes.
// - Wrap disable bit resets to one.
// - Without wrap the address steps by one after each byte.
module mfre_engine #(
   parameter AW = 24
) (
   input  wire          sys_clk_i,
   input  wire          rst_i,
   input  wire          cs_n_i,
   input  wire          sclk_i,
   input  wire [3:0]    io_i,
   output wire [3:0]    io_o,
   output wire [3:0]    io_oe_o,
   input  wire          quad_enable_bit_i,
   input  wire          quad_instruction_mode_i,
   input  wire          wrap_set_i,
   input  wire [2:0]    wrap_bits_i,
   input  wire          rd_param_set_i,
   input  wire [1:0]    rd_param_i,
   input  wire          soft_reset_i,
   output wire          mem_rd_o,
   output wire [AW-1:0] mem_addr_o,
   input  wire [7:0]    mem_rdata_i,
   output wire          execute_in_place_o,
   output wire          busy_o
);
   localparam ST_IDLE  = 7'h01;
   localparam ST_CMD   = 7'h02;
   localparam ST_ADDR  = 7'h04;
   localparam ST_MODE  = 7'h08;
   localparam ST_DUMMY = 7'h10;
   localparam ST_DATA  = 7'h20;
   localparam ST_IGN   = 7'h40;

   // Pin synchronisers
   reg  [2:0]    sclk_s_ff;
   reg  [2:0]    csn_s_ff;
   reg  [3:0]    io_s1_ff;
   reg  [3:0]    io_s2_ff;
   reg  [3:0]    io_s3_ff;
   reg           sclk_lvl_ff;
   reg           csn_lvl_ff;
   wire          sclk_ok;
   wire          csn_ok;
   wire          sclk_rise;
   wire          sclk_fall;
   wire          cs_fall;
   wire          cs_rise;

   reg  [6:0]    st_ff;
   reg  [6:0]    nxt_st;
   reg  [4:0]    cnt_ff;
   reg  [4:0]    nxt_cnt;
   reg  [23:0]   sh_ff;
   reg  [23:0]   nxt_sh;
   reg  [1:0]    kind_ff;
   reg  [1:0]    nxt_kind;
   reg           cont_ff;
   reg  [1:0]    cont_kind_ff;
   reg           wrap_dis_ff;
   reg  [1:0]    wrap_len_ff;
   reg  [1:0]    rdpar_ff;
   reg  [2:0]    in_w;
   reg  [4:0]    ph_len;
   reg  [4:0]    dummy_len;
   reg           fetch_on_ff;
   reg  [AW-1:0] fetch_addr_ff;
   reg           rd_pend_ff;
   reg           wrap_act_ff;
   reg  [7:0]    out_sh_ff;
   reg  [1:0]    out_left_ff;
   reg  [3:0]    io_out_ff;
   reg  [3:0]    io_oe_ff;
   wire          phase_end;
   wire [4:0]    cnt_inc;
   wire          buf_in_ready;
   wire          buf_out_valid;
   wire [7:0]    buf_out_data;
   wire          out_load;
   wire [7:0]    out_byte;
   wire [7:0]    wrap_mask;
   wire [AW-1:0] addr_inc;
   wire [AW-1:0] addr_step;

   // Three-flop sampling; a change counts once stages two and three agree
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_s_ff <= 3'h0;
         csn_s_ff  <= 3'h7;
         io_s1_ff  <= 4'h0;
         io_s2_ff  <= 4'h0;
         io_s3_ff  <= 4'h0;
      end else begin
         sclk_s_ff <= {sclk_s_ff[1:0], sclk_i};
         csn_s_ff  <= {csn_s_ff[1:0], cs_n_i};
         io_s1_ff  <= io_i;
         io_s2_ff  <= io_s1_ff;
         io_s3_ff  <= io_s2_ff;
      end
   end

   assign sclk_ok   = (sclk_s_ff[1] == sclk_s_ff[2]);
   assign csn_ok    = (csn_s_ff[1] == csn_s_ff[2]);
   assign sclk_rise = sclk_ok & sclk_s_ff[2] & ~sclk_lvl_ff & ~csn_lvl_ff;
   assign sclk_fall = sclk_ok & ~sclk_s_ff[2] & sclk_lvl_ff & ~csn_lvl_ff;
   assign cs_fall   = csn_ok & ~csn_s_ff[2] & csn_lvl_ff;
   assign cs_rise   = csn_ok & csn_s_ff[2] & ~csn_lvl_ff;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sclk_lvl_ff <= 1'b0;
         csn_lvl_ff  <= 1'b1;
      end else begin
         if (sclk_ok) begin
            sclk_lvl_ff <= sclk_s_ff[2];
         end
         if (csn_ok) begin
            csn_lvl_ff <= csn_s_ff[2];
         end
      end
   end

   // Setup registers
   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wrap_dis_ff <= `MFRE_WRAP_DIS_RST;
         wrap_len_ff <= `MFRE_WRAP_LEN_RST;
         rdpar_ff    <= `MFRE_RDPAR_RST;
      end else begin
         if (wrap_set_i) begin
            wrap_dis_ff <= wrap_bits_i[`MFRE_WRAP_DIS_BIT];
            wrap_len_ff <= wrap_bits_i[`MFRE_WRAP_LEN_HI:`MFRE_WRAP_LEN_LO];
         end
         // dummy select, reset instruction restores zero
         if (soft_reset_i) begin
            rdpar_ff <= `MFRE_RDPAR_RST;
         end else if (rd_param_set_i) begin
            rdpar_ff <= rd_param_i;
         end
      end
   end

   // Lines sampled per rising edge in the current phase
   always @* begin
      in_w = 3'h1;
      if (st_ff == ST_CMD) begin
         in_w = quad_instruction_mode_i ? 3'h4 : 3'h1;
      end else if (st_ff == ST_ADDR || st_ff == ST_MODE) begin
         case (kind_ff)
            `MFRE_KIND_DIO: in_w = 3'h2;
            `MFRE_KIND_QIO: in_w = 3'h4;
            default:        in_w = 3'h1;
         endcase
      end
   end

   always @* begin
      case (in_w)
         3'h2:    nxt_sh = {sh_ff[21:0], io_s3_ff[1:0]};
         3'h4:    nxt_sh = {sh_ff[19:0], io_s3_ff[3:0]};
         default: nxt_sh = {sh_ff[22:0], io_s3_ff[0]};
      endcase
   end

   // Dummy clocks after the mode byte, or after the address for quad output, per kind
   always @* begin
      case (kind_ff)
         `MFRE_KIND_QO:  dummy_len = `MFRE_DUMMY_CLKS_QO;
         `MFRE_KIND_DIO: dummy_len = `MFRE_DUMMY_CLKS_DIO;
         default: begin
            if (quad_instruction_mode_i) begin
               dummy_len = {2'h0, rdpar_ff, 1'b0};
            end else begin
               dummy_len = `MFRE_DUMMY_CLKS_QIO;
            end
         end
      endcase
   end

   always @* begin
      case (st_ff)
         ST_CMD: begin
            ph_len = quad_instruction_mode_i ? `MFRE_CMD_CLKS_QPI : `MFRE_CMD_CLKS_SPI;
         end
         ST_ADDR: begin
            case (kind_ff)
               `MFRE_KIND_DIO: ph_len = `MFRE_ADDR_CLKS_X2;
               `MFRE_KIND_QIO: ph_len = `MFRE_ADDR_CLKS_X4;
               default:        ph_len = `MFRE_ADDR_CLKS_X1;
            endcase
         end
         ST_MODE: begin
            ph_len = (kind_ff == `MFRE_KIND_DIO) ? `MFRE_MODE_CLKS_X2 : `MFRE_MODE_CLKS_X4;
         end
         ST_DUMMY: ph_len = dummy_len;
         default:  ph_len = 5'h1F;
      endcase
   end

   assign cnt_inc   = cnt_ff + 5'h1;
   assign phase_end = (cnt_inc == ph_len);

   // Command decode and phase sequencing on rising edges
   always @* begin
      nxt_st   = st_ff;
      nxt_cnt  = cnt_ff;
      nxt_kind = kind_ff;
      case (st_ff)
         ST_IDLE: begin
            if (cs_fall) begin
               if (cont_ff) begin
                  nxt_st   = ST_ADDR;
                  nxt_kind = cont_kind_ff;
               end else begin
                  nxt_st = ST_CMD;
               end
               nxt_cnt = 5'h0;
            end
         end
         ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY: begin
            if (sclk_rise) begin
               nxt_cnt = phase_end ? 5'h0 : cnt_inc;
               if (phase_end) begin
                  case (st_ff)
                     ST_CMD: begin
                        nxt_st = ST_IGN;
                        if (quad_instruction_mode_i) begin
                           if (nxt_sh[7:0] == `MFRE_OP_QUAD_IO && quad_enable_bit_i) begin
                              nxt_st   = ST_ADDR;
                              nxt_kind = `MFRE_KIND_QIO;
                           end
                        end else if (nxt_sh[7:0] == `MFRE_OP_QUAD_OUT) begin
                           if (quad_enable_bit_i) begin
                              nxt_st   = ST_ADDR;
                              nxt_kind = `MFRE_KIND_QO;
                           end
                        end else if (nxt_sh[7:0] == `MFRE_OP_DUAL_IO) begin
                           nxt_st   = ST_ADDR;
                           nxt_kind = `MFRE_KIND_DIO;
                        end else if (nxt_sh[7:0] == `MFRE_OP_QUAD_IO) begin
                           if (quad_enable_bit_i) begin
                              nxt_st   = ST_ADDR;
                              nxt_kind = `MFRE_KIND_QIO;
                           end
                        end
                     end
                     ST_ADDR: begin
                        nxt_st = (kind_ff == `MFRE_KIND_QO) ? ST_DUMMY : ST_MODE;
                     end
                     ST_MODE: begin
                        nxt_st = (dummy_len == 5'h0) ? ST_DATA : ST_DUMMY;
                     end
                     default: nxt_st = ST_DATA;
                  endcase
               end
            end
         end
         default: nxt_st = st_ff;
      endcase
      if (cs_rise) begin
         nxt_st = ST_IDLE;
      end
   end

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff        <= ST_IDLE;
         cnt_ff       <= 5'h0;
         kind_ff      <= `MFRE_KIND_QO;
         sh_ff        <= 24'h000000;
         cont_ff      <= 1'b0;
         cont_kind_ff <= `MFRE_KIND_DIO;
      end else begin
         st_ff   <= nxt_st;
         cnt_ff  <= nxt_cnt;
         kind_ff <= nxt_kind;
         if (sclk_rise) begin
            sh_ff <= nxt_sh;
         end
         if (st_ff == ST_MODE && sclk_rise && phase_end) begin
            // any other value restores opcode decoding
            cont_ff      <= (nxt_sh[`MFRE_SKIP_HI:`MFRE_SKIP_LO] == `MFRE_SKIP_KEEP);
            cont_kind_ff <= kind_ff;
         end
      end
   end

   // Address stepping with optional section wrap
   assign wrap_mask = (8'h08 << wrap_len_ff) - 8'h01;
   assign addr_inc  = fetch_addr_ff + {{(AW-1){1'b0}}, 1'b1};
   assign addr_step = wrap_act_ff ?
                      {fetch_addr_ff[AW-1:8],
                       (fetch_addr_ff[7:0] & ~wrap_mask) | (addr_inc[7:0] & wrap_mask)} :
                      addr_inc;

   assign mem_rd_o   = fetch_on_ff & ~rd_pend_ff & buf_in_ready;
   assign mem_addr_o = fetch_addr_ff;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         fetch_on_ff   <= 1'b0;
         fetch_addr_ff <= {AW{1'b0}};
         rd_pend_ff    <= 1'b0;
         wrap_act_ff   <= 1'b0;
      end else begin
         rd_pend_ff <= mem_rd_o;
         if (cs_rise) begin
            fetch_on_ff <= 1'b0;
         end else if (st_ff == ST_ADDR && sclk_rise && phase_end) begin
            fetch_on_ff   <= 1'b1;
            fetch_addr_ff <= nxt_sh[AW-1:0];
            // no wrap in quad-instruction mode or when disabled
            wrap_act_ff   <= (kind_ff == `MFRE_KIND_QIO) & ~quad_instruction_mode_i &
                             ~wrap_dis_ff;
         end else if (mem_rd_o) begin
            fetch_addr_ff <= addr_step;
         end
      end
   end

   mfre_buf2 #(
      .DW (8)
   ) u_buf (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .flush_i     (cs_rise),
      .in_valid_i  (rd_pend_ff & fetch_on_ff),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (mem_rdata_i),
      .out_valid_o (buf_out_valid),
      .out_ready_i (out_load),
      .out_data_o  (buf_out_data)
   );

   // Data shifting on falling edges
   assign out_load = (st_ff == ST_DATA) & sclk_fall & (out_left_ff == 2'h0);
   assign out_byte = buf_out_valid ? buf_out_data : 8'hFF;

   always @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         out_sh_ff   <= 8'h00;
         out_left_ff <= 2'h0;
         io_out_ff   <= 4'h0;
         io_oe_ff    <= 4'h0;
      end else if (cs_rise || st_ff != ST_DATA) begin
         out_left_ff <= 2'h0;
         io_oe_ff    <= 4'h0;
      end else if (sclk_fall) begin
         // drive only from first data falling edge
         if (kind_ff == `MFRE_KIND_DIO) begin
            io_oe_ff <= 4'h3;
            if (out_left_ff == 2'h0) begin
               io_out_ff   <= {2'h0, out_byte[7:6]};
               out_sh_ff   <= {out_byte[5:0], 2'h0};
               out_left_ff <= 2'h3;
            end else begin
               io_out_ff   <= {2'h0, out_sh_ff[7:6]};
               out_sh_ff   <= {out_sh_ff[5:0], 2'h0};
               out_left_ff <= out_left_ff - 2'h1;
            end
         end else begin
            io_oe_ff <= 4'hF;
            if (out_left_ff == 2'h0) begin
               io_out_ff   <= out_byte[7:4];
               out_sh_ff   <= {out_byte[3:0], 4'h0};
               out_left_ff <= 2'h1;
            end else begin
               io_out_ff   <= out_sh_ff[7:4];
               out_left_ff <= 2'h0;
            end
         end
      end
   end

   assign io_o               = io_out_ff;
   assign io_oe_o            = io_oe_ff;
   assign execute_in_place_o = cont_ff;
   assign busy_o             = ~csn_lvl_ff;
endmodule

// ---- test/mfre_engine_asserts.sv ----
// Port checker of the fast read engine
`timescale 1ns/1ps
module mfre_engine_asserts (
   input wire logic       sys_clk_i,
   input wire logic       rst_i,
   input wire logic       cs_n_i,
   input wire logic       sclk_i,
   input wire logic [3:0] io_o,
   input wire logic [3:0] io_oe_o,
   input wire logic       quad_enable_bit_i,
   input wire logic       execute_in_place_o,
   input wire logic       busy_o
);
   logic [3:0] cs_hi_ff;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Cycles since chip select went high
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) cs_hi_ff <= 4'h0;
      else if (!cs_n_i) cs_hi_ff <= 4'h0;
      else if (cs_hi_ff != 4'hF) cs_hi_ff <= cs_hi_ff + 4'h1;
   end
   property p_oe_shape;
      io_oe_o == 4'h0 || io_oe_o == 4'h3 || io_oe_o == 4'hF;
   endproperty
   a_oe_shape: assert property (p_oe_shape)
      else $error("enable pattern not 0, 3 or F");
   property p_idle;
      cs_hi_ff >= 4'h8 |-> io_oe_o == 4'h0 && !busy_o;
   endproperty
   a_idle: assert property (p_idle)
      else $error("active while deselected");
   property p_no_quad;
      !quad_enable_bit_i |-> io_oe_o != 4'hF;
   endproperty
   a_no_quad: assert property (p_no_quad)
      else $error("quad data without quad enable");
   property p_sel_busy;
      $fell(cs_n_i) ##1 !cs_n_i [*5] |-> busy_o;
   endproperty
   a_sel_busy: assert property (p_sel_busy)
      else $error("busy missing after select");
   property p_oe_release;
      $rose(cs_n_i) |-> ##[1:6] io_oe_o == 4'h0;
   endproperty
   a_oe_release: assert property (p_oe_release)
      else $error("lines still driven after deselect");
   property p_fall_launch;
      sclk_i && $past(sclk_i, 2) |-> $stable(io_o);
   endproperty
   a_fall_launch: assert property (p_fall_launch)
      else $error("data changed while clock high");
   property p_skip_arm;
      $rose(execute_in_place_o) |-> busy_o;
   endproperty
   a_skip_arm: assert property (p_skip_arm)
      else $error("skip armed outside a transfer");
   property p_skip_drop;
      $fell(execute_in_place_o) |-> busy_o;
   endproperty
   a_skip_drop: assert property (p_skip_drop)
      else $error("skip cleared outside a transfer");
endmodule

bind mfre_engine mfre_engine_asserts u_chk (.sys_clk_i, .rst_i, .cs_n_i, .sclk_i, .io_o,
   .io_oe_o, .quad_enable_bit_i, .execute_in_place_o, .busy_o);

// ---- test/mfre_host_model.sv ----
// Host serial flash controller model
`timescale 1ns/1ps
`include "mfre_map.vh"
module mfre_host_model (
   input  wire logic [3:0] dev_io_i,
   input  wire logic [3:0] dev_oe_i,
   input  wire logic       sys_clk_i,
   output logic            cs_n_o,
   output logic            sclk_o,
   output logic [3:0]      io_line_o
);
   logic [3:0] drv_ff = 4'h0;
   logic [3:0] hoe_ff = 4'h0;
   logic [7:0] rx [0:7];
   logic       saw_oe = 1'h0;
   int         gap = 0;
   initial cs_n_o = 1'h1;
   initial sclk_o = 1'h0;
   // Released lines show the inverse of the last driven value
   assign io_line_o = (dev_oe_i & dev_io_i) | (~dev_oe_i & hoe_ff & drv_ff)
                    | (~dev_oe_i & ~hoe_ff & ~drv_ff);
   always @(posedge sys_clk_i) if (!cs_n_o && dev_oe_i != 4'h0) saw_oe <= 1'h1;
   task automatic cyc(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] got);
      if (oe != 4'h0) drv_ff <= v;
      hoe_ff <= oe;
      repeat (4 + gap) @(posedge sys_clk_i);
      sclk_o <= 1'h1;
      repeat (4 + gap) @(posedge sys_clk_i);
      got = io_line_o;
      sclk_o <= 1'h0;
   endtask
   task automatic send(input logic [23:0] val, input int nb, input int w);
      logic [3:0] g;
      logic [23:0] s;
      s = val << (24 - nb);
      for (int i = 0; i < nb / w; i++) begin
         g = (w == 4) ? s[23:20] : (w == 2) ? {2'h0, s[23:22]} : {3'h0, s[23]};
         cyc(g, (4'h1 << w) - 4'h1, g);
         s = s << w;
      end
   endtask
   task automatic xfer(input logic [1:0] kind, input logic quad_instruction_mode, input logic skip,
                       input logic [1:0] par, input logic [23:0] addr,
                       input logic [7:0] mode, input int n);
      int w;
      int dum;
      int dw;
      logic [3:0] g;
      logic [7:0] by;
      w = (kind == `MFRE_KIND_QO) ? 1 : (kind == `MFRE_KIND_DIO) ? 2 : 4;
      dw = (kind == `MFRE_KIND_DIO) ? 2 : 4;
      dum = (kind == `MFRE_KIND_QO) ? 8 : (kind == `MFRE_KIND_DIO) ? 0 : quad_instruction_mode ? 2 * par : 4;
      saw_oe = 1'h0;
      cs_n_o <= 1'h0;
      repeat (8) @(posedge sys_clk_i);
      if (!skip) send((kind == `MFRE_KIND_QO) ? `MFRE_OP_QUAD_OUT :
         (kind == `MFRE_KIND_DIO) ? `MFRE_OP_DUAL_IO : `MFRE_OP_QUAD_IO, 8, quad_instruction_mode ? 4 : 1);
      send(addr, 24, w);
      if (kind != `MFRE_KIND_QO) send({16'h0, mode}, 8, w);
      for (int i = 0; i < dum; i++) cyc(4'hA, (i < dum - 4) ? 4'hF : 4'h0, g);
      for (int b = 0; b < n; b++) begin
         for (int c = 0; c < 8 / dw; c++) begin
            cyc(4'h0, 4'h0, g);
            by = (dw == 4) ? {by[3:0], g} : {by[5:0], g[1:0]};
         end
         rx[b] = by;
      end
      repeat (4) @(posedge sys_clk_i);
      cs_n_o <= 1'h1;
      repeat (12) @(posedge sys_clk_i);
   endtask
endmodule

// ---- test/tb.sv ----
// Self-checking bench of the fast read engine
`timescale 1ns/1ps
`include "mfre_map.vh"
module tb;
   typedef struct packed {
      logic [1:0]  kind;
      logic        quad_instruction_mode;
      logic        skip;
      logic        qe;
      logic [1:0]  par;
      logic [2:0]  wb;
      logic [23:0] addr;
      logic [7:0]  mode;
      logic [2:0]  n;
   } mfre_row_t;
   localparam mfre_row_t ROWS [0:15] = '{
      '{2'h0, 1'h0, 1'h0, 1'h1, 2'h0, 3'h1, 24'h0000FE, 8'h00, 3'h3},
      '{2'h0, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1, 24'h000010, 8'h00, 3'h2},
      '{2'h1, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1, 24'h123456, 8'h20, 3'h2},
      '{2'h1, 1'h0, 1'h1, 1'h1, 2'h0, 3'h1, 24'h555555, 8'h55, 3'h2},
      '{2'h1, 1'h0, 1'h0, 1'h1, 2'h0, 3'h1, 24'h000020, 8'h00, 3'h1},
      '{2'h2, 1'h0, 1'h0, 1'h1, 2'h0, 3'h1, 24'h2000F7, 8'hA5, 3'h2},
      '{2'h2, 1'h0, 1'h1, 1'h1, 2'h0, 3'h1, 24'h111111, 8'h11, 3'h2},
      '{2'h2, 1'h0, 1'h0, 1'h0, 2'h0, 3'h1, 24'h000030, 8'h20, 3'h2},
      '{2'h0, 1'h1, 1'h0, 1'h1, 2'h0, 3'h1, 24'h000030, 8'h00, 3'h2},
      '{2'h2, 1'h1, 1'h0, 1'h1, 2'h0, 3'h1, 24'h000040, 8'h20, 3'h2},
      '{2'h2, 1'h1, 1'h1, 1'h1, 2'h1, 3'h1, 24'h000050, 8'hFF, 3'h2},
      '{2'h2, 1'h1, 1'h0, 1'h1, 2'h3, 3'h0, 24'h000006, 8'h00, 3'h4},
      '{2'h2, 1'h0, 1'h0, 1'h1, 2'h0, 3'h0, 24'h000106, 8'h00, 3'h4},
      '{2'h2, 1'h0, 1'h0, 1'h1, 2'h0, 3'h2, 24'h00000E, 8'h00, 3'h4},
      '{2'h2, 1'h0, 1'h0, 1'h1, 2'h0, 3'h4, 24'h00001E, 8'h00, 3'h4},
      '{2'h2, 1'h0, 1'h0, 1'h1, 2'h0, 3'h6, 24'h00013E, 8'h00, 3'h4}};
   logic sys_clk_i = 1'h0, rst_i = 1'h1, cs_n_i, sclk_i, mem_rd_o, execute_in_place_o, busy_o;
   logic quad_enable_bit_i = 1'h0, quad_instruction_mode_i = 1'h0, wrap_set_i = 1'h0;
   logic rd_param_set_i = 1'h0, soft_reset_i = 1'h0, xip_exp = 1'h0;
   logic [2:0]  wrap_bits_i = 3'h1;
   logic [1:0]  rd_param_i = 2'h0;
   logic [3:0]  io_i, io_o, io_oe_o;
   logic [7:0]  mem_rdata_i = 8'h00;
   logic [23:0] mem_addr_o;
   int mismatches = 0, comparisons = 0, cycles = 0;
   mfre_engine dut (.sys_clk_i, .rst_i, .cs_n_i, .sclk_i, .io_i, .io_o, .io_oe_o,
      .quad_enable_bit_i, .quad_instruction_mode_i, .wrap_set_i, .wrap_bits_i,
      .rd_param_set_i, .rd_param_i, .soft_reset_i, .mem_rd_o, .mem_addr_o, .mem_rdata_i,
      .execute_in_place_o, .busy_o);
   mfre_host_model h (.sys_clk_i, .dev_io_i(io_o), .dev_oe_i(io_oe_o), .cs_n_o(cs_n_i),
      .sclk_o(sclk_i), .io_line_o(io_i));
   always #12.5 sys_clk_i = ~sys_clk_i;
   function automatic logic [7:0] mfre_byte(input logic [23:0] a);
      return a[7:0] ^ a[15:8] ^ 8'h3C;
   endfunction
   // Array answers one cycle after each request
   always @(posedge sys_clk_i) if (mem_rd_o) mem_rdata_i <= mfre_byte(mem_addr_o);
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   function automatic logic [23:0] exp_addr(input mfre_row_t r, input int i);
      logic [23:0] m;
      m = (24'h8 << r.wb[2:1]) - 24'h1;
      if (r.kind == `MFRE_KIND_QIO && !r.quad_instruction_mode && !r.wb[0])
         return (r.addr & ~m) | ((r.addr + i) & m);
      return r.addr + i;
   endfunction
   task automatic pulse(input logic wr, input logic pr, input logic sr);
      wrap_set_i <= wr;
      rd_param_set_i <= pr;
      soft_reset_i <= sr;
      @(posedge sys_clk_i);
      {wrap_set_i, rd_param_set_i, soft_reset_i} <= 3'h0;
      @(posedge sys_clk_i);
   endtask
   task automatic run_row(input mfre_row_t r);
      logic ok;
      ok = (r.kind == `MFRE_KIND_DIO || r.qe) && (!r.quad_instruction_mode || r.kind == `MFRE_KIND_QIO);
      quad_enable_bit_i <= r.qe;
      quad_instruction_mode_i <= r.quad_instruction_mode;
      wrap_bits_i <= r.wb;
      rd_param_i <= r.par;
      pulse(1'h1, 1'h1, 1'h0);
      h.xfer(r.kind, r.quad_instruction_mode, r.skip, r.par, r.addr, r.mode, r.n);
      for (int b = 0; b < r.n && ok; b++) chk("data", mfre_byte(exp_addr(r, b)), h.rx[b]);
      if (!ok) chk("refused drive", 8'h00, {7'h0, h.saw_oe});
      if (ok && r.kind != `MFRE_KIND_QO) xip_exp = (r.mode[5:4] == 2'h2);
      chk("skip armed", {7'h0, xip_exp}, {7'h0, execute_in_place_o});
      $display("test done: kind %0d addr %h", r.kind, r.addr);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      for (int i = 0; i < 16; i++) begin
         h.gap = (i >= 14) ? 12 : 0;
         run_row(ROWS[i]);
      end
      h.gap = 0;
      // Soft reset returns dummies to zero
      quad_instruction_mode_i <= 1'h1;
      rd_param_i <= 2'h3;
      pulse(1'h0, 1'h1, 1'h0);
      pulse(1'h0, 1'h0, 1'h1);
      h.xfer(`MFRE_KIND_QIO, 1'h1, 1'h0, 2'h0, 24'h000060, 8'h00, 2);
      for (int b = 0; b < 2; b++) chk("soft reset", mfre_byte(24'h60 + b), h.rx[b]);
      $display("test done: soft reset");
      // Wrap on, then reset while deselected between reads must turn it off
      wrap_bits_i <= 3'h0;
      quad_instruction_mode_i <= 1'h0;
      pulse(1'h1, 1'h0, 1'h0);
      rst_i <= 1'h1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'h0;
      repeat (4) @(posedge sys_clk_i);
      h.xfer(`MFRE_KIND_QIO, 1'h0, 1'h0, 2'h0, 24'h000007, 8'h00, 2);
      for (int b = 0; b < 2; b++) chk("wrap reset", mfre_byte(24'h07 + b), h.rx[b]);
      chk("skip reset", 8'h00, {7'h0, execute_in_place_o});
      $display("test done: wrap reset");
      end_sim();
   end
endmodule
